// >>> pph_port.sv
// Parallel port handshake engine: transmit and receive directions
`default_nettype none
// Operation
// (RULE1) Ack pin is always an input, strobe pin always an output.
// (RULE2) Transmit: strobe output is data strobe, receiver ack drives ack input.
// (RULE3) Receive: sender strobe enters ack input, its ack is our strobe.
// (RULE4) Strobe pulse lasts N times two clocks, N from low five bits.
// (RULE5) Transmit: next strobe waits for acknowledge of previous byte.
// (RULE6) Transmit: busy line is not used for flow control.
// (RULE7) Receive: busy rises on falling edge of incoming strobe.
// (RULE8) Receive: busy falls after our acknowledge pulse ends.
// (RULE9) Receive: acknowledge issued within fifteen two-clock units of strobe.
// (RULE10) Sender waits ten units after our ack falls before next strobe.
// (RULE11) Receive rate should make half bit exceed strobe width.
// (RULE12) Data bus driven only when transmitting; captured at incoming strobe.
module pph_port
  import pph_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic TX_MODE,
  input wire logic [7:0] TX_BIT_PERIOD_REG,
  input wire logic TX_VALID,
  output logic TX_READY,
  input wire logic [DATA_W-1:0] TX_DATA,
  output logic RX_VALID,
  output logic [DATA_W-1:0] RX_DATA,
  input wire logic PORT_ACK_IN_N,
  output logic PORT_STROBE_OUT_N,
  output logic PORT_BUSY_OUT,
  input wire logic [DATA_W-1:0] PORT_DATA_BUS_I,
  output logic [DATA_W-1:0] PORT_DATA_BUS_O,
  output logic PORT_DATA_BUS_OE
);
  pph_core_type s_q, s_d;
  logic f_valid, f_ready;
  logic [DATA_W-1:0] f_data;
  logic [N_W-1:0] n_field;
  logic [6:0] strobe_cycles;
  logic ack_fall, ack_rise, ack_agree;

  pph_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .PW(FIFO_PTR_W)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(TX_VALID),
    .in_ready(TX_READY),
    .in_data(TX_DATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Field value zero stands for 32 units
  assign n_field = TX_BIT_PERIOD_REG[N_FIELD_LSB +: N_W];
  assign strobe_cycles = (n_field == '0) ? 7'(32 * UNIT_CYC) :
                         7'(n_field) * 7'(UNIT_CYC); // RULE4

  // Only stages two and three feed the edge detection
  assign ack_agree = (s_q.ack_sync[1] == s_q.ack_sync[2]);
  assign ack_fall = ack_agree && s_q.ack_level && !s_q.ack_sync[2];
  assign ack_rise = ack_agree && !s_q.ack_level && s_q.ack_sync[2];
  assign f_ready = (s_q.st == PPH_IDLE) && TX_MODE && f_valid;

  always_comb begin
    s_d = s_q;
    s_d.ack_sync = {s_q.ack_sync[1:0], PORT_ACK_IN_N}; // RULE1
    s_d.din_sync = {s_q.din_sync[2*DATA_W-1:0], PORT_DATA_BUS_I};
    if (ack_agree) s_d.ack_level = s_q.ack_sync[2];
    s_d.rx_valid = 1'b0;
    if (s_q.cnt != CNT_ZERO) s_d.cnt = s_q.cnt - 7'd1;
    case (s_q.st)
      PPH_IDLE: begin
        s_d.strobe_n = 1'b1;
        s_d.drive = TX_MODE; // RULE12
        if (!TX_MODE) s_d.busy = 1'b0;
        if (TX_MODE && f_valid) begin
          // Data is set up one unit before the strobe falls
          s_d.dout = f_data;
          s_d.cnt = 7'(UNIT_CYC);
          s_d.st = PPH_TX_SETUP;
        end else if (!TX_MODE && ack_fall) begin
          s_d.busy = 1'b1; // RULE7
          s_d.st = PPH_RX_HOLD;
        end
      end
      PPH_TX_SETUP: begin
        if (s_q.cnt <= 7'd1) begin
          s_d.strobe_n = 1'b0; // RULE2
          s_d.cnt = strobe_cycles;
          s_d.ack_seen = 1'b0;
          s_d.st = PPH_TX_STROBE;
        end
      end
      PPH_TX_STROBE: begin
        if (ack_fall) s_d.ack_seen = 1'b1;
        if (s_q.cnt <= 7'd1) begin
          s_d.strobe_n = 1'b1;
          s_d.st = PPH_TX_WAIT_ACK;
        end
      end
      PPH_TX_WAIT_ACK: begin
        // Busy is ignored here; only the acknowledge paces bytes
        if (ack_fall || s_q.ack_seen) s_d.st = PPH_TX_WAIT_REL; // RULE5 RULE6
      end
      PPH_TX_WAIT_REL: begin
        if (ack_rise || (s_q.ack_level && ack_agree)) s_d.st = PPH_IDLE; // RULE5
      end
      PPH_RX_HOLD: begin
        // Byte taken at the strobe's rising edge, inside the hold window
        if (ack_rise) begin
          s_d.rx_data = s_q.din_sync[3*DATA_W-1:2*DATA_W]; // RULE12
          s_d.rx_valid = 1'b1;
          s_d.cnt = 7'(RX_ACK_DELAY_UNITS) * 7'(UNIT_CYC);
          s_d.st = PPH_RX_STROBE;
        end
      end
      PPH_RX_STROBE: begin
        // Ack starts well inside the fifteen unit bound
        if (s_q.cnt <= 7'd1 && s_q.strobe_n) begin
          s_d.strobe_n = 1'b0; // RULE9 RULE3
          s_d.cnt = strobe_cycles; // RULE4
        end else if (s_q.cnt <= 7'd1) begin
          s_d.strobe_n = 1'b1;
          s_d.st = PPH_RX_DONE;
        end
      end
      PPH_RX_DONE: begin
        s_d.busy = 1'b0; // RULE8
        s_d.st = PPH_IDLE;
      end
      default: s_d.st = PPH_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.ack_sync <= 3'h7;
      s_q.ack_level <= 1'b1;
      s_q.strobe_n <= 1'b1;
      s_q.st <= PPH_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign PORT_STROBE_OUT_N = s_q.strobe_n;
  assign PORT_BUSY_OUT = s_q.busy;
  assign PORT_DATA_BUS_O = s_q.dout;
  assign PORT_DATA_BUS_OE = s_q.drive;
  assign RX_VALID = s_q.rx_valid;
  assign RX_DATA = s_q.rx_data;
endmodule
`default_nettype wire

// >>> pph_pkg.sv
// Package for the parallel port handshake block
`default_nettype none
package pph_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_PTR_W = 4;
  localparam int N_W = 5;
  localparam int UNIT_CYC = 2;
  localparam int N_FIELD_LSB = 0;
  localparam logic [7:0] TX_PERIOD_RST = 8'h41;
  localparam logic [5:0] RX_ACK_TIMEOUT_UNITS = 6'h0F;
  localparam logic [5:0] RX_ACK_DELAY_UNITS = 6'h01;
  localparam logic [6:0] CNT_ZERO = 7'h00;

  typedef enum {
    PPH_IDLE, PPH_TX_SETUP, PPH_TX_STROBE, PPH_TX_WAIT_ACK, PPH_TX_WAIT_REL,
    PPH_RX_HOLD, PPH_RX_STROBE, PPH_RX_DONE
  } pph_state_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
  } pph_byte_type;

  typedef struct packed {
    logic [2:0] ack_sync;
    logic ack_level;
    pph_state_type st;
    logic [6:0] cnt;
    logic strobe_n;
    logic busy;
    logic drive;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic [3*DATA_W-1:0] din_sync;
    logic ack_seen;
  } pph_core_type;
endpackage
`default_nettype wire

// >>> pph_fifo.sv
// Parameterised valid/ready FIFO for the transmit byte stream
`default_nettype none
module pph_fifo
  import pph_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int PW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
    logic rdy;
  } pph_fifo_type;

  logic [WIDTH-1:0] mem [DEPTH];
  pph_fifo_type s_q, s_d;
  logic push, pop;

  // Ready is registered so no path runs from the count to the writer
  assign in_ready = s_q.rdy;
  assign out_valid = (s_q.count != '0);
  assign out_data = mem[s_q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) s_d.wr = s_q.wr + PW'(1);
    if (pop) s_d.rd = s_q.rd + PW'(1);
    if (push && !pop) s_d.count = s_q.count + (PW+1)'(1);
    else if (pop && !push) s_d.count = s_q.count - (PW+1)'(1);
    s_d.rdy = (s_d.count != (PW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (rst) s_q <= '{wr: '0, rd: '0, count: '0, rdy: 1'b1};
    else s_q <= s_d;
    if (push) mem[s_q.wr] <= in_data;
  end
endmodule
`default_nettype wire

// >>> pph_port_props.sv
// Checker for the parallel port handshake engine
`default_nettype none
module pph_port_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TX_MODE,
  input wire logic PORT_ACK_IN_N,
  input wire logic PORT_STROBE_OUT_N,
  input wire logic PORT_BUSY_OUT,
  input wire logic PORT_DATA_BUS_OE
);
  wire logic t = TX_MODE;
  wire logic a = PORT_ACK_IN_N;
  wire logic s = PORT_STROBE_OUT_N;
  wire logic b = PORT_BUSY_OUT;
  logic owed_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Owed from the end of a sent byte until the receiver's acknowledge rises again
  always_ff @(posedge CLK)
    if (RST) owed_q <= 1'b0;
    else if (t && $rose(s)) owed_q <= 1'b1;
    else if ($rose(a)) owed_q <= 1'b0;
  bus_rx_a: assert property (
    !t && !$past(t, 3) |-> !PORT_DATA_BUS_OE) else $error("bus driven");
  strobe_min_a: assert property (
    $fell(s) |-> !s [*2]) else $error("strobe too short");
  strobe_max_a: assert property (
    $fell(s) |-> ##[2:64] $rose(s)) else $error("strobe too long");
  busy_rise_a: assert property (
    !t && $fell(a) && !b |-> ##[1:6] b) else $error("busy late");
  busy_hold_a: assert property (
    !t && !s |-> b) else $error("busy low in ack");
  busy_fall_a: assert property (
    !t && $rose(s) |-> ##[0:2] !b) else $error("busy stuck");
  ack_due_a: assert property (
    !t && $rose(a) && b |-> ##[1:30] !s) else $error("ack late");
  tx_order_a: assert property (
    owed_q |-> s) else $error("strobe before ack");
  cover property (t && $fell(s));
  cover property (!t && $rose(b));
  cover property (owed_q ##1 !owed_q);
endmodule
`default_nettype wire

// >>> pph_partner.sv
// Far side model: printer in transmit, byte sender in receive
`default_nettype none
module pph_partner (
  input wire logic clk,
  input wire logic tx_mode,
  input wire logic strobe_n,
  input wire logic [7:0] bus,
  output logic ack_n,
  output logic [7:0] drv
);
  timeunit 1ns;
  timeprecision 1ps;
  int dly = 4;
  logic [7:0] got[$];
  initial begin
    ack_n = 1'b1;
    drv = 8'h5A;
  end
  // Ack pulse of 64 clocks keeps the 250 ns minimum width
  always @(negedge strobe_n) if (tx_mode) begin
    got.push_back(bus);
    @(posedge strobe_n);
    repeat (dly) @(posedge clk);
    #1 ack_n = 1'b0;
    repeat (64) @(posedge clk);
    #1 ack_n = 1'b1;
  end
  // Data and strobe move just after an edge, never on it
  task automatic send(input logic [7:0] v);
    @(posedge clk) #1 drv = v;
    @(posedge clk) #1 ack_n = 1'b0;
    repeat (64) @(posedge clk);
    #1 ack_n = 1'b1;
    for (int i = 0; i < 40 && strobe_n !== 1'b0; i++) @(posedge clk);
    #1 drv = ~v;
    repeat (20) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Testbench for the parallel port handshake engine
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, md = 0, vld = 0, rv, rdy, sn, bsy, ack, oe;
  logic [7:0] txd = 0, rxd, bus, drv, dout, per = 8'hE3;
  int num_errors = 0, check_count = 0, wid = 0, last = 0, n, w;
  logic [7:0] rq[$];
  assign bus = oe ? dout : drv;
  pph_port u_pph_port (.CLK(CLK), .RST(RST), .TX_MODE(md),
    .TX_BIT_PERIOD_REG(per), .TX_VALID(vld), .TX_READY(rdy),
    .TX_DATA(txd), .RX_VALID(rv), .RX_DATA(rxd), .PORT_ACK_IN_N(ack),
    .PORT_STROBE_OUT_N(sn), .PORT_BUSY_OUT(bsy), .PORT_DATA_BUS_I(bus),
    .PORT_DATA_BUS_O(dout), .PORT_DATA_BUS_OE(oe));
  pph_partner u_pph_partner (.clk(CLK), .tx_mode(md), .strobe_n(sn),
    .bus(bus), .ack_n(ack), .drv(drv));
  initial forever #2 CLK = ~CLK;
  always @(posedge CLK) begin
    if (rv === 1'b1) rq.push_back(rxd);
    if (sn === 1'b0) wid <= wid + 1;
    else if (wid != 0) begin
      last <= wid;
      wid <= 0;
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Slow printer so the buffer fills until it refuses
  task automatic t_tx;
    md = 1;
    u_pph_partner.dly = 60;
    @(posedge CLK) #1 vld = 1;
    for (n = 0; n < 20 && rdy === 1'b1; n++) begin
      txd = 8'(n * 37);
      @(posedge CLK) #1;
    end
    vld = 0;
    chk("refused", {7'h00, rdy}, 8'h00);
    chk("filled", 8'(n >= 16), 8'h01);
    for (w = 0; w < 9000 && u_pph_partner.got.size() < n; w++)
      @(posedge CLK);
    for (w = 0; w < n; w++)
      chk("tx byte", u_pph_partner.got[w], 8'(w * 37));
    chk("tx width", 8'(last), 8'h06);
    // Let the last acknowledge finish before the direction changes
    repeat (200) @(posedge CLK);
    $display("test tx done");
  endtask
  task automatic t_rx;
    #1 md = 0;
    u_pph_partner.send(8'h3C);
    chk("rx width", 8'(last), 8'h06);
    // Field value zero gives the longest pulse of 32 units
    #1 per = 8'h20;
    u_pph_partner.send(8'hC3);
    repeat (80) @(posedge CLK);
    chk("rx count", 8'(rq.size()), 8'h02);
    chk("rx byte", rq[0], 8'h3C);
    chk("rx byte", rq[1], 8'hC3);
    chk("rx width max", 8'(last), 8'h40);
    $display("test rx done");
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    #1 RST = 0;
    @(posedge CLK) #1;
    chk("idle", {5'h00, sn, bsy, oe}, 8'h04);
    $display("test reset done");
    t_tx;
    t_rx;
    final_report;
  end
  initial begin
    #200000;
    num_errors++;
    final_report;
  end
endmodule
bind pph_port pph_port_props u_pph_port_props (.CLK(CLK), .RST(RST),
  .TX_MODE(TX_MODE), .PORT_ACK_IN_N(PORT_ACK_IN_N),
  .PORT_STROBE_OUT_N(PORT_STROBE_OUT_N), .PORT_BUSY_OUT(PORT_BUSY_OUT),
  .PORT_DATA_BUS_OE(PORT_DATA_BUS_OE));
`default_nettype wire
